// [shared/tdm_switch_map.svh]
// register offsets, field positions, reset values and codes of the switch
// assumes apb byte addressing with one aligned 32-bit word per register
//
// Operation
// [RULE_01] cancel: command 0x70 loads unassigned code
// [RULE_02] command 0x60 with nibble 0000 floats slot
// [RULE_03] tristate nibble 1111 drives all bits
// [RULE_04] command 0x60 reaches the tristate field
// [RULE_05] code 0001 switches all eight bits
// [RULE_06] entry per line slot holds pcm pointer
// [RULE_07] code sets bandwidth and pcm position
// [RULE_08] per-port mode fixes line-side position
// [RULE_09] one subslot per line slot, pcm mixes
// [RULE_10] select register: two mode bits per port
// [RULE_11] pcm position fixed by code, any mode
// [RULE_12] mode 00: nibble 7:4, pair 7:6
// [RULE_13] mode 01: nibble 3:0, pair 5:4
// [RULE_14] mode 10: nibble 7:4, pair 3:2
// [RULE_15] mode 11: nibble 3:0, pair 1:0
// [RULE_16] bit 7 first, eight contiguous bits
// [RULE_17] leading-zero nonzero code means switched
// [RULE_18] tristate bit k enables pair k
// [RULE_19] memory access starts on command write
`ifndef TDM_SWITCH_MAP_SVH
`define TDM_SWITCH_MAP_SVH
`define OFS_MEM_DATA 8'h00
`define OFS_MEM_ADDR 8'h04
`define OFS_MEM_COMMAND 8'h08
`define OFS_SUBSLOT_SEL 8'h0c
`define OFS_FRAME_STATUS 8'h10
`define SUBSLOT_SEL_RESET 8'h00
`define CODE_UNASSIGNED 4'h0
`define CODE_FULL 4'h1
`define CODE_NIB_HI 4'h3
`define CODE_NIB_LO 4'h2
`define LINE_IDLE_BYTE 8'hff
`define PCM_IDLE_BYTE 8'hff
`define UPSTREAM_BIT 7
`define BIT_DIV_DEFAULT 16
`endif

// [shared/tdm_switch_pkg.sv]
// types used by the switch core; its timer and its lane mapper do not import them
// assumes the constants of tdm_switch_map.svh
package tdm_switch_pkg;
   // upper command nibble selects the memory operation
   typedef enum logic [3:0] {
      OP_WR_PTR_CODE = 4'h7,
      OP_WR_PTR = 4'h4,
      OP_WR_TRI = 4'h6,
      OP_RD_PTR = 4'hc,
      OP_RD_CODE = 4'hf,
      OP_RD_TRI = 4'he
   } mem_op_t;
   typedef logic [6:0] slot_t;
endpackage : tdm_switch_pkg

// [shared/frame_timing_if.sv]
// frame timing handed from the timer to the switch core
// assumes one clock domain, pclk
interface frame_timing_if;
   logic bit_en;
   logic [6:0] slot;
   logic [2:0] bit_idx;
   logic frame_start;
   modport src (output bit_en, output slot, output bit_idx, output frame_start);
   modport snk (input bit_en, input slot, input bit_idx, input frame_start);
endinterface : frame_timing_if

// [core/frame_timer.sv]
// bit-rate enable and slot/bit counters for a 128-slot frame
// assumes pclk and an asynchronous active-low reset
module frame_timer #(
   parameter int BIT_DIV = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   frame_timing_if.src tim
);
   typedef struct packed {
      logic [15:0] div;
      logic [6:0] slot;
      logic [2:0] bit_idx;
   } timer_state_t;
   timer_state_t q_r, q_nxt;

   if (BIT_DIV < 2 || BIT_DIV > 65535) begin : g_chk
      $error("frame_timer: BIT_DIV out of range");
   end

   always_comb
   begin
      q_nxt = q_r;
      if (q_r.div == 16'(BIT_DIV - 1))
      begin
         q_nxt.div = 16'h0000;
         q_nxt.bit_idx = q_r.bit_idx - 3'h1;
         if (q_r.bit_idx == 3'h0)
            q_nxt.slot = q_r.slot + 7'h01;
      end
      else
         q_nxt.div = q_r.div + 16'h0001;
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         q_r <= '{div: 16'h0000, slot: 7'h00, bit_idx: 3'h7};
      else
         q_r <= q_nxt;

   assign tim.bit_en = (q_r.div == 16'(BIT_DIV - 1));
   assign tim.slot = q_r.slot;
   assign tim.bit_idx = q_r.bit_idx;
   assign tim.frame_start = tim.bit_en && q_r.slot == 7'h00 && q_r.bit_idx == 3'h7;
endmodule : frame_timer

// [core/subslot_mapper.sv]
// moves one switched field from a source byte into a destination byte
// assumes code has a leading zero and is not unassigned
module subslot_mapper (
   input wire logic [3:0] code,
   input wire logic [1:0] mode,
   input wire logic to_pcm,
   input wire logic [7:0] src,
   input wire logic [7:0] dst,
   output logic [7:0] merged
);
   logic [7:0] wmask;
   logic [2:0] pcm_lsb;
   logic [2:0] line_lsb;
   logic [7:0] field;
   always_comb
   begin
      // [RULE_05] [RULE_07] [RULE_11] width and pcm position
      unique case (code[2:1])
         2'b00: wmask = 8'hff;
         2'b01: wmask = 8'h0f;
         default: wmask = 8'h03;
      endcase
      pcm_lsb = 3'h0;
      if (code[2:1] == 2'b01)
         pcm_lsb = code[0] ? 3'h4 : 3'h0;
      else if (code[2])
         pcm_lsb = {code[1:0], 1'b0};
      // [RULE_08] [RULE_12] [RULE_13] [RULE_14] [RULE_15] line position
      line_lsb = 3'h0;
      if (code[2:1] == 2'b01)
         line_lsb = mode[0] ? 3'h0 : 3'h4;
      else if (code[2])
         line_lsb = 3'(3'h6 - {mode, 1'b0});
      // [RULE_09] one field moved, rest of destination kept
      field = (src >> (to_pcm ? line_lsb : pcm_lsb)) & wmask;
      merged = (dst & ~(wmask << (to_pcm ? pcm_lsb : line_lsb)))
         | (field << (to_pcm ? pcm_lsb : line_lsb));
   end
endmodule : subslot_mapper

// [core/tdm_subslot_switch.sv]
// time/space switch core: apb registers, connection memory, serial lanes
// assumes one line-side lane and one pcm lane of 128 slots, pins asynchronous
`include "tdm_switch_map.svh"
module tdm_subslot_switch #(
   parameter int BIT_DIV = `BIT_DIV_DEFAULT
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic line_rx,
   output logic line_tx,
   input wire logic pcm_rx,
   output logic pcm_tx,
   output logic pcm_tx_oe,
   output logic frame_sync
);
   import tdm_switch_pkg::*;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] addr;
      logic [7:0] cmd;
      logic [7:0] sel;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic line_meta;
      logic line_sync;
      logic pcm_meta;
      logic pcm_sync;
      logic [7:0] line_rx_sh;
      logic [7:0] pcm_rx_sh;
      logic [7:0] line_tx_sh;
      logic [7:0] pcm_tx_sh;
      logic [3:0] tri_cur;
      logic line_tx;
      logic pcm_tx;
      logic pcm_oe;
      logic frame;
   } core_state_t;
   core_state_t q_r, q_nxt;

   // connection memory: bit 7 of the index picks upstream entries
   logic [7:0] cm_ptr [256];
   logic [3:0] cm_code [256];
   logic [3:0] tri_mem [128];
   logic [7:0] pcm_store [128];
   logic [7:0] up_store [128];

   frame_timing_if tim ();
   frame_timer #(.BIT_DIV(BIT_DIV)) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .tim(tim.src)
   );

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   logic setup_ph;
   logic wr_go;
   logic cmd_go;
   logic mapped;
   mem_op_t op;
   assign setup_ph = psel && !penable;
   assign wr_go = psel && penable && pwrite && q_r.pready && !q_r.pslverr;
   // [RULE_19] command write starts the access
   assign cmd_go = wr_go && paddr == `OFS_MEM_COMMAND;
   assign op = mem_op_t'(pwdata[7:4]);
   assign mapped = paddr == `OFS_MEM_DATA || paddr == `OFS_MEM_ADDR
      || paddr == `OFS_MEM_COMMAND || paddr == `OFS_SUBSLOT_SEL
      || paddr == `OFS_FRAME_STATUS;

   ////////////////////////////////////////////////////////////////////////
   // switching datapath
   slot_t slot;
   logic slot_start;
   logic slot_end;
   logic [7:0] line_rx_byte;
   logic [7:0] pcm_rx_byte;
   logic [1:0] port_mode;
   logic [7:0] down_idx;
   logic [7:0] up_idx;
   logic [3:0] down_code;
   logic [3:0] up_code;
   logic down_on;
   logic up_on;
   logic [7:0] down_byte;
   logic [7:0] up_merged;
   logic [7:0] line_tx_byte;
   logic [7:0] pcm_tx_byte;

   assign slot = tim.slot;
   assign slot_start = tim.bit_en && tim.bit_idx == 3'h7;
   assign slot_end = tim.bit_en && tim.bit_idx == 3'h0;
   // [RULE_16] bit 7 shifts in first
   assign line_rx_byte = {q_r.line_rx_sh[6:0], q_r.line_sync};
   assign pcm_rx_byte = {q_r.pcm_rx_sh[6:0], q_r.pcm_sync};
   // four ports of 32 slots each
   assign port_mode = q_r.sel[{slot[6:5], 1'b0} +: 2];
   assign down_idx = {1'b0, slot};
   assign up_idx = {1'b1, slot};
   // [RULE_06] entry of the line slot points at a pcm slot
   assign down_code = cm_code[down_idx];
   assign up_code = cm_code[up_idx];
   // [RULE_17] switched only for nonzero codes with leading zero
   assign down_on = !down_code[3] && down_code != `CODE_UNASSIGNED;
   assign up_on = !up_code[3] && up_code != `CODE_UNASSIGNED;

   subslot_mapper u_down_map (
      .code(down_code),
      .mode(port_mode),
      .to_pcm(1'b0),
      .src(pcm_store[cm_ptr[down_idx][6:0]]),
      .dst(`LINE_IDLE_BYTE),
      .merged(down_byte)
   );
   subslot_mapper u_up_map (
      .code(up_code),
      .mode(port_mode),
      .to_pcm(1'b1),
      .src(line_rx_byte),
      .dst(up_store[cm_ptr[up_idx][6:0]]),
      .merged(up_merged)
   );
   assign line_tx_byte = down_on ? down_byte : `LINE_IDLE_BYTE;
   assign pcm_tx_byte = up_store[slot];

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      q_nxt = q_r;
      // pins pass two flops before use
      q_nxt.line_meta = line_rx;
      q_nxt.line_sync = q_r.line_meta;
      q_nxt.pcm_meta = pcm_rx;
      q_nxt.pcm_sync = q_r.pcm_meta;

      // zero wait states: answer is prepared during setup
      q_nxt.pready = 1'b0;
      q_nxt.pslverr = 1'b0;
      if (setup_ph)
      begin
         q_nxt.pready = 1'b1;
         q_nxt.pslverr = !mapped;
         unique case (paddr)
            `OFS_MEM_DATA: q_nxt.prdata = {24'h000000, q_r.data};
            `OFS_MEM_ADDR: q_nxt.prdata = {24'h000000, q_r.addr};
            `OFS_MEM_COMMAND: q_nxt.prdata = {24'h000000, q_r.cmd};
            // [RULE_10] select register reads back
            `OFS_SUBSLOT_SEL: q_nxt.prdata = {24'h000000, q_r.sel};
            `OFS_FRAME_STATUS: q_nxt.prdata = {22'h0, slot, tim.bit_idx};
            default: q_nxt.prdata = 32'h00000000;
         endcase
      end
      if (wr_go)
      begin
         unique case (paddr)
            `OFS_MEM_DATA: q_nxt.data = pwdata[7:0];
            `OFS_MEM_ADDR: q_nxt.addr = pwdata[7:0];
            `OFS_MEM_COMMAND: q_nxt.cmd = pwdata[7:0];
            // [RULE_10] two mode bits per port
            `OFS_SUBSLOT_SEL: q_nxt.sel = pwdata[7:0];
            default: q_nxt.cmd = q_r.cmd;
         endcase
      end
      // read operations land in the data register
      if (cmd_go)
      begin
         if (op == OP_RD_PTR)
            q_nxt.data = cm_ptr[q_r.addr];
         else if (op == OP_RD_CODE)
            q_nxt.data = {4'h0, cm_code[q_r.addr]};
         else if (op == OP_RD_TRI)
            q_nxt.data = {4'h0, tri_mem[q_r.addr[6:0]]};
      end

      if (tim.bit_en)
      begin
         q_nxt.line_rx_sh = line_rx_byte;
         q_nxt.pcm_rx_sh = pcm_rx_byte;
         q_nxt.line_tx_sh = {q_r.line_tx_sh[6:0], 1'b1};
         q_nxt.pcm_tx_sh = {q_r.pcm_tx_sh[6:0], 1'b1};
         q_nxt.line_tx = q_r.line_tx_sh[7];
         q_nxt.pcm_tx = q_r.pcm_tx_sh[7];
         // [RULE_18] pair k driven while nibble bit k is set
         q_nxt.pcm_oe = q_r.tri_cur[tim.bit_idx[2:1]];
         // [RULE_16] load whole slot, send bit 7 at once
         if (slot_start)
         begin
            q_nxt.line_tx_sh = {line_tx_byte[6:0], 1'b1};
            q_nxt.pcm_tx_sh = {pcm_tx_byte[6:0], 1'b1};
            q_nxt.line_tx = line_tx_byte[7];
            q_nxt.pcm_tx = pcm_tx_byte[7];
            q_nxt.tri_cur = tri_mem[slot];
            q_nxt.pcm_oe = tri_mem[slot][3];
         end
      end
      q_nxt.frame = tim.frame_start;
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         q_r <= '0;
         q_r.sel <= `SUBSLOT_SEL_RESET;
         q_r.line_tx <= 1'b1;
         q_r.pcm_tx <= 1'b1;
      end
      else
         q_r <= q_nxt;

   ////////////////////////////////////////////////////////////////////////
   // memories
   // codes and tristate fields reset so no slot switches or drives early
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         for (int i = 0; i < 256; i++)
            cm_code[i] <= `CODE_UNASSIGNED;
         for (int i = 0; i < 128; i++)
            tri_mem[i] <= 4'h0;
      end
      else if (cmd_go)
      begin
         // [RULE_01] [RULE_05] [RULE_07] code from the command low nibble
         if (op == OP_WR_PTR_CODE)
            cm_code[q_r.addr] <= pwdata[3:0];
         // [RULE_02] [RULE_03] [RULE_04] tristate field from data nibble
         if (op == OP_WR_TRI)
            tri_mem[q_r.addr[6:0]] <= q_r.data[3:0];
      end

   // pointer and sample stores carry data only and need no reset
   always_ff @(posedge pclk)
   begin
      // [RULE_06] pointer taken from the data register
      if (cmd_go && (op == OP_WR_PTR_CODE || op == OP_WR_PTR))
         cm_ptr[q_r.addr] <= q_r.data;
      if (slot_end)
         pcm_store[slot] <= pcm_rx_byte;
      // [RULE_09] merge keeps other subslots of the pcm slot
      if (slot_end && up_on)
         up_store[cm_ptr[up_idx][6:0]] <= up_merged;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata = q_r.prdata;
   assign pready = q_r.pready;
   assign pslverr = q_r.pslverr;
   assign line_tx = q_r.line_tx;
   assign pcm_tx = q_r.pcm_tx;
   assign pcm_tx_oe = q_r.pcm_oe;
   assign frame_sync = q_r.frame;
endmodule : tdm_subslot_switch

// [testbench/tdm_switch_checker.sv]
// checker for the switch core: apb answers, select register, serial framing
// assumes it is bound to tdm_subslot_switch and shares its BIT_DIV
module tdm_switch_checker #(
   parameter int BIT_DIV = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic line_tx,
   input wire logic pcm_tx_oe,
   input wire logic frame_sync
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FRAME = 1024 * BIT_DIV;
   logic wr;
   logic cmd;
   logic [7:0] sel_r;
   logic tri_r;
   logic conn_r;
   logic seen_r;
   int cnt_r;
   assign wr = psel && penable && pready && pwrite;
   assign cmd = wr && paddr == 8'h08;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////
   // shadows of what software has asked for so far
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sel_r <= 8'h00;
         tri_r <= 1'b0;
         conn_r <= 1'b0;
         seen_r <= 1'b0;
         cnt_r <= 0;
      end
      else
      begin
         if (wr && paddr == 8'h0c)
            sel_r <= pwdata[7:0];
         if (cmd && pwdata[7:4] == 4'h6)
            tri_r <= 1'b1;
         if (cmd && pwdata[7:4] == 4'h7 && pwdata[3:0] != 4'h0)
            conn_r <= 1'b1;
         seen_r <= seen_r || frame_sync;
         cnt_r <= frame_sync ? 0 : cnt_r + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_select_readback: assert property (
      pready && !pwrite && paddr == 8'h0c |-> prdata == {24'h000000, sel_r})
      else $error("select readback differs");
   a_unmapped_err: assert property (pready && paddr >= 8'h14 |-> pslverr)
      else $error("unmapped access not refused");
   a_sync_single: assert property (frame_sync |=> (!frame_sync) [*7])
      else $error("frame pulse too wide");
   a_frame_length: assert property (frame_sync && seen_r |-> cnt_r == FRAME - 1)
      else $error("frame length wrong");
   a_bit_hold: assert property ($changed(line_tx) |=> $stable(line_tx))
      else $error("line bit too short");
   a_float_default: assert property (!tri_r |-> !pcm_tx_oe)
      else $error("pcm driven unasked");
   a_line_idle: assert property (!conn_r |-> line_tx)
      else $error("line busy without connection");
   c_command: cover property (cmd);
   c_refused: cover property (pslverr);
   c_frame: cover property (frame_sync && seen_r);
endmodule : tdm_switch_checker

bind tdm_subslot_switch tdm_switch_checker #(.BIT_DIV(BIT_DIV)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .line_tx(line_tx), .pcm_tx_oe(pcm_tx_oe), .frame_sync(frame_sync));

// [testbench/serial_far_end.sv]
// far-end model of the pcm highway and the line card, one fixed byte per slot
// assumes frame_sync marks slot 0 bit 7 and BIT_DIV clocks per bit
module serial_far_end #(
   parameter int BIT_DIV = 16
) (
   input wire logic pclk,
   input wire logic frame_sync,
   input wire logic line_tx,
   input wire logic pcm_tx,
   input wire logic pcm_tx_oe,
   output logic line_rx,
   output logic pcm_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   int cyc = 0;
   int s;
   int b;
   int ds;
   int db;
   logic [7:0] line_seen [128];
   logic [7:0] pcm_seen [128];
   logic [7:0] oe_seen [128];
   function automatic logic [7:0] src_byte(input int slot, input logic up);
      return up ? 8'(slot * 5 + 1) : 8'(slot * 7 + 66);
   endfunction : src_byte
   initial
   begin
      line_rx = 1'b1;
      pcm_rx = 1'b1;
   end
   always @(posedge pclk)
   begin
      cyc = frame_sync ? 0 : cyc + 1;
      s = cyc / BIT_DIV / 8 % 128;
      b = 7 - cyc / BIT_DIV % 8;
      ds = (cyc + BIT_DIV / 2) / BIT_DIV / 8 % 128;
      db = 7 - (cyc + BIT_DIV / 2) / BIT_DIV % 8;
      // next bit leaves half a bit early: the two input flops eat the lead,
      // so it settles before the design's sampling edge; tx is read mid-bit
      if (cyc % BIT_DIV == BIT_DIV / 2)
      begin
         line_rx <= 1'(src_byte(ds, 1'b1) >> db);
         pcm_rx <= 1'(src_byte(ds, 1'b0) >> db);
         line_seen[s][b] = line_tx;
         oe_seen[s][b] = pcm_tx_oe;
         pcm_seen[s][b] = pcm_tx_oe ? pcm_tx : !pcm_seen[s][b];
      end
   end
endmodule : serial_far_end

// [testbench/tdm_subchannel_switch_programming_tb.sv]
// bench for the switch core: apb programming checked on the serial lanes
// assumes serial_far_end on the lanes and the bound checker
module tdm_subchannel_switch_programming_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BD = 8;
   localparam logic [7:0] SEL = 8'he4;
   typedef struct packed {logic up; logic [6:0] ls; logic [6:0] ps; logic [3:0] code;} row_t;
   // ports 0..3 sit in modes 00..11; codes 9 and 0 leave the slot idle
   localparam row_t ROWS [14] = '{'{0, 1, 10, 1}, '{0, 2, 11, 3}, '{0, 33, 12, 2},
      '{0, 34, 13, 7}, '{0, 65, 14, 6}, '{0, 66, 15, 5}, '{0, 67, 19, 2}, '{0, 97, 16, 4},
      '{0, 98, 17, 3}, '{0, 99, 18, 9}, '{0, 100, 18, 0}, '{1, 4, 20, 1}, '{1, 5, 21, 7},
      '{1, 37, 21, 4}};
   localparam logic [11:0] TRI [5] = '{12'h14f, 12'h15f, 12'h165, 12'h17f, 12'h170};
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0, msk, src, ex, got;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, line_rx, line_tx, pcm_rx, pcm_tx, pcm_tx_oe, frame_sync, er;
   logic [1:0] m;
   int err_total = 0, checks = 0, pl, ll, n;
   always #2.5 pclk = ~pclk;
   tdm_subslot_switch #(.BIT_DIV(BD)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .line_rx(line_rx), .line_tx(line_tx),
      .pcm_rx(pcm_rx), .pcm_tx(pcm_tx), .pcm_tx_oe(pcm_tx_oe), .frame_sync(frame_sync));
   serial_far_end #(.BIT_DIV(BD)) far (.pclk(pclk), .frame_sync(frame_sync),
      .line_tx(line_tx), .pcm_tx(pcm_tx), .pcm_tx_oe(pcm_tx_oe), .line_rx(line_rx),
      .pcm_rx(pcm_rx));
   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   task automatic bail(input logic bad);
      if (bad)
      begin
         err_total++;
         finish_test();
      end
   endtask : bail
   task automatic compare(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask : compare
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
         @(posedge pclk);
      while (pready !== 1'b1 && ++n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      bail(n >= 16);
   endtask : apb
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h0c, 0);
      compare("select at reset", 0, rd);
      apb(1'b1, 8'h0c, {24'hffffff, SEL});
      apb(1'b0, 8'h0c, 0);
      compare("select", SEL, rd);
      apb(1'b1, 8'h20, 1);
      compare("refused", 1, er);
      $display("register test done");
      foreach (ROWS[i])
      begin
         apb(1'b1, 8'h00, ROWS[i].ps);
         apb(1'b1, 8'h04, {ROWS[i].up, ROWS[i].ls});
         apb(1'b1, 8'h08, {4'h7, ROWS[i].code});
      end
      foreach (TRI[i])
      begin
         apb(1'b1, 8'h00, TRI[i][3:0]);
         apb(1'b1, 8'h04, TRI[i][11:4]);
         apb(1'b1, 8'h08, 32'h60);
      end
      // line slot 6 joined to pcm slot 0, then cut again
      apb(1'b1, 8'h04, 6);
      apb(1'b1, 8'h08, 32'h71);
      apb(1'b1, 8'h08, 32'h70);
      apb(1'b1, 8'h04, 2);
      apb(1'b1, 8'h08, 32'hc0);
      apb(1'b0, 8'h00, 0);
      compare("pointer", 11, rd);
      repeat (3)
      begin
         n = 0;
         do
            @(posedge pclk);
         while (frame_sync !== 1'b1 && ++n < 2048 * BD);
         bail(frame_sync !== 1'b1);
      end
      // right after the frame pulse the status slot field is still 0
      apb(1'b0, 8'h10, 0);
      compare("status slot", 0, rd >> 3);
      foreach (ROWS[i])
      begin
         m = 2'(SEL >> (2 * ROWS[i].ls[6:5]));
         msk = ROWS[i].code == 4'h1 ? 8'hff : (ROWS[i].code[3:1] == 3'b001 ? 8'h0f : 8'h03);
         pl = msk == 8'hff ? 0 : (msk == 8'h0f ? 4 * ROWS[i].code[0] : 2 * ROWS[i].code[1:0]);
         ll = msk == 8'hff ? 0 : (msk == 8'h0f ? 4 * !m[0] : 6 - 2 * m);
         src = far.src_byte(ROWS[i].up ? ROWS[i].ls : ROWS[i].ps, ROWS[i].up);
         ex = ROWS[i].code[3] || ROWS[i].code == 4'h0 ? 8'hff :
            8'(~(msk << ll) | (((src >> pl) & msk) << ll));
         got = far.line_seen[ROWS[i].ls];
         if (ROWS[i].up)
         begin
            ex = (src >> ll) & msk;
            got = (far.pcm_seen[ROWS[i].ps] >> pl) & msk;
         end
         compare("switched field", ex, got);
      end
      compare("cancelled", 8'hff, far.line_seen[6]);
      compare("all driven", 8'hff, far.oe_seen[20]);
      compare("pairs driven", 8'h33, far.oe_seen[22]);
      compare("floated", 8'h00, far.oe_seen[23]);
      compare("untouched", 8'h00, far.oe_seen[30]);
      apb(1'b1, 8'h04, 8'h16);
      apb(1'b1, 8'h08, 32'he0);
      apb(1'b0, 8'h00, 0);
      compare("tristate readback", 5, rd);
      // pointer-only write must leave the code of line slot 2 alone
      apb(1'b1, 8'h00, 12);
      apb(1'b1, 8'h04, 2);
      apb(1'b1, 8'h08, 32'h40);
      apb(1'b1, 8'h08, 32'hc0);
      apb(1'b0, 8'h00, 0);
      compare("pointer only", 12, rd);
      apb(1'b1, 8'h08, 32'hf0);
      apb(1'b0, 8'h00, 0);
      compare("code kept", 3, rd);
      $display("switching test done");
      finish_test();
   end
endmodule : tdm_subchannel_switch_programming_tb
